// ===== rtl/tbp_pkg.sv
// timer pwm block: register map, field positions, reset values
// assumes a 32-bit apb slave with one word per register
package tbp_pkg;

    // ----------------------------------------------------------
    // register byte addresses and channel register address high nibbles
    // ----------------------------------------------------------
    localparam logic [7:0] ADDR_SC = 8'h00;
    localparam logic [7:0] ADDR_CNT = 8'h04;
    localparam logic [7:0] ADDR_MOD = 8'h08;
    localparam logic [3:0] ADDR_CHSC_HI = 4'h1;
    localparam logic [3:0] ADDR_CHV_HI = 4'h2;

    // ----------------------------------------------------------
    // timer status and control fields
    // ----------------------------------------------------------
    localparam int SC_OVF_BIT = 7;
    localparam int SC_OVIE_BIT = 6;
    localparam int SC_HALT_BIT = 5;
    localparam int SC_RST_BIT = 4;
    localparam int SC_PS_LSB = 0;
    localparam logic [2:0] PS_EXT = 3'h7;

    // ----------------------------------------------------------
    // channel status and control fields
    // ----------------------------------------------------------
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_CTL_W = 7;

    // ----------------------------------------------------------
    // reset values
    // ----------------------------------------------------------
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [15:0] CNT_RST = 16'h0000;

    typedef struct packed {
        logic ovIe;
        logic halt;
        logic [2:0] ps;
    } tbp_ctl_s;

    // order matches channel register bits 6..0
    typedef struct packed {
        logic ie;
        logic bufSel;
        logic unbufSel;
        logic elsHi;
        logic elsLo;
        logic tov;
        logic maxDuty;
    } tbp_chc_s;

    localparam tbp_ctl_s CTL_RST = '{ovIe: 1'b0, halt: 1'b1, ps: 3'h0};
    localparam tbp_chc_s CHC_RST = '0;

endpackage

// ===== rtl/tbp_timer_pwm.sv
// four-channel 16-bit timer with buffered pwm pairs, apb registers
// assumes apb master on clock; pins sampled synchronously to clock
//
// Summary of operation
// RULE_01: buffer bit of channel 0 links 0/1, output on pin 0, channel 0 first
// RULE_02: write to inactive member takes over at next overflow; last written governs
// RULE_03: when linked, channel 1 control unused and pin 1 released
// RULE_04: channel 2 buffer bit links 2/3 likewise, pin 3 released
// RULE_05: buffer bit beats unbuffered select bit
// RULE_06: software writes only the inactive member of a pair
// RULE_07: software stops, resets, programs period, width, mode, then restarts
// RULE_08: software programs mode bits 0:1 unbuffered or 1:0 buffered; the bench's pair tests write 1:1
// RULE_09: software sets toggle-on-overflow and compare action to pulse complement
// RULE_10: software avoids toggle-on-compare in pwm
// RULE_11: toggle-on-overflow clear gives zero percent duty
// RULE_12: max duty plus toggle-on-overflow gives hundred percent duty
// RULE_13: overflow flag set at modulo; request only with its enable
// RULE_14: channel flag on capture or compare; request only with its enable
// RULE_15: flag clears by read-with-flag then write 0; new event voids it
// RULE_16: reset clears overflow flag and overflow enable
// RULE_17: in wait registers locked, timer runs, enabled request wakes
// RULE_18: software stops timer before wait when not needed
// RULE_19: prescale code 111 selects external clock, pin forced to input
// RULE_20: each channel pin is capture or compare independently
// RULE_21: halt bit stops counter; reset sets it
// RULE_22: counter reset bit clears counter and prescaler, reads zero
// RULE_23: prescale codes 000..110 divide by 1..64, 111 external
// RULE_24: period is overflow spacing, width is overflow to compare
// RULE_25: external clock synchronised, counter steps on rising edge
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module tbp_timer_pwm
    import tbp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic waitMode,
    input wire logic extCountClock,
    output logic extClkInputForce,
    input wire logic [3:0] channelPinIn,
    output logic [3:0] channelPinOut,
    output logic [3:0] channelPinOe,
    output logic irq
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    tbp_ctl_s ctl_r, ctl_nxt;
    tbp_chc_s chc_r [4];
    tbp_chc_s chc_nxt [4];
    logic [15:0] cmp_r [4];
    logic [15:0] cmp_nxt [4];
    logic [3:0] chFlag_r, chFlag_nxt;
    logic [3:0] chArm_r, chArm_nxt;
    logic [3:0] out_r, out_nxt;
    logic [3:0] pinPrev_r, pinPrev_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic [1:0] lastWr_r, lastWr_nxt;
    logic ovf_r, ovf_nxt;
    logic ovArm_r, ovArm_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] mod_r, mod_nxt;
    logic [5:0] presc_r, presc_nxt;
    logic [2:0] ext_r, ext_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // ----------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------
    logic access, setupRd, wr, rst;
    logic [5:0] pmask;
    logic tick, ovfEvt;
    logic [3:0] linked, oc, cap, cmpHit, chEvt;
    logic [3:0] wrSc, wrV;
    logic [15:0] cmpVal;
    logic [1:0] fa;

    // sticky flag step: read-arm, write-0 clear, event wins
    function automatic logic [1:0] flag_step(input logic f, input logic arm, input logic evt,
                                             input logic rdHit, input logic wr0);
        logic nf;
        logic na;
        nf = f;
        na = arm;
        if (rdHit && f) begin
            na = 1'b1;
        end
        if (wr0 && arm) begin
            nf = 1'b0;
            na = 1'b0;
        end
        if (evt) begin
            nf = 1'b1;
            na = 1'b0;
        end
        return {nf, na};
    endfunction

    // address is a mapped register
    function automatic logic addr_ok(input logic [7:0] a);
        return (a == ADDR_SC) || (a == ADDR_CNT) || (a == ADDR_MOD) ||
               (a[7:4] == ADDR_CHSC_HI && a[1:0] == 2'b00) ||
               (a[7:4] == ADDR_CHV_HI && a[1:0] == 2'b00);
    endfunction

    // ----------------------------------------------------------
    // apb handshake, always ready
    // ----------------------------------------------------------
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && (waitMode || !addr_ok(paddr)); // [RULE_17]
    assign prdata = rdata_r;
    assign extClkInputForce = (ctl_r.ps == PS_EXT); // [RULE_19]
    assign channelPinOut = out_r;

    // request when any enabled flag stands; also wakes from wait
    assign irq = (ovf_r && ctl_r.ovIe) || |(chFlag_r & {chc_r[3].ie, chc_r[2].ie, chc_r[1].ie, chc_r[0].ie}); // [RULE_13] [RULE_14] [RULE_17]

    // ----------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------
    always_comb begin
        ctl_nxt = ctl_r;
        chc_nxt = chc_r;
        cmp_nxt = cmp_r;
        chFlag_nxt = chFlag_r;
        chArm_nxt = chArm_r;
        out_nxt = out_r;
        pinPrev_nxt = channelPinIn;
        sel_nxt = sel_r;
        lastWr_nxt = lastWr_r;
        mod_nxt = mod_r;
        rdata_nxt = rdata_r;
        channelPinOe = 4'h0;
        linked = 4'h0;
        oc = 4'h0;
        cap = 4'h0;
        cmpHit = 4'h0;
        chEvt = 4'h0;
        wrSc = 4'h0;
        wrV = 4'h0;
        cmpVal = 16'h0000;
        // registers locked while in wait
        wr = access && pwrite && !waitMode; // [RULE_17]
        setupRd = psel && !penable && !pwrite && !waitMode;
        rst = wr && (paddr == ADDR_SC) && pwdata[SC_RST_BIT];

        // two-stage sync then edge detect on external clock
        ext_nxt = {ext_r[1:0], extCountClock}; // [RULE_25]
        // prescaler tap: divide by 2^ps
        pmask = 6'((7'd1 << ctl_r.ps) - 7'd1); // [RULE_23]
        if (ctl_r.ps == PS_EXT) begin
            tick = !ctl_r.halt && ext_r[1] && !ext_r[2]; // [RULE_19] [RULE_25]
        end else begin
            tick = !ctl_r.halt && ((presc_r & pmask) == pmask); // [RULE_23]
        end
        // halted counter and prescaler hold
        presc_nxt = ctl_r.halt ? presc_r : presc_r + 6'd1; // [RULE_21]
        ovfEvt = tick && (cnt_r == mod_r); // [RULE_13] [RULE_24]
        cnt_nxt = cnt_r;
        if (tick) begin
            cnt_nxt = ovfEvt ? CNT_RST : cnt_r + 16'd1;
        end
        if (rst) begin
            cnt_nxt = CNT_RST; // [RULE_22]
            presc_nxt = 6'd0; // [RULE_22]
        end

        // timer control register
        if (wr && paddr == ADDR_SC) begin
            ctl_nxt.ovIe = pwdata[SC_OVIE_BIT];
            ctl_nxt.halt = pwdata[SC_HALT_BIT]; // [RULE_21]
            ctl_nxt.ps = pwdata[SC_PS_LSB +: 3]; // [RULE_23]
        end
        fa = flag_step(ovf_r, ovArm_r, ovfEvt, setupRd && paddr == ADDR_SC,
                       wr && paddr == ADDR_SC && !pwdata[SC_OVF_BIT]); // [RULE_15]
        ovf_nxt = fa[1]; // [RULE_13]
        ovArm_nxt = fa[0];
        if (wr && paddr == ADDR_MOD) begin
            mod_nxt = pwdata[15:0];
        end

        // channel decode, modes and events
        for (int i = 0; i < 4; i++) begin
            linked[i] = chc_r[i & 2].bufSel; // [RULE_01] [RULE_04]
            wrSc[i] = wr && paddr[7:4] == ADDR_CHSC_HI && paddr[3:2] == 2'(i);
            wrV[i] = wr && paddr[7:4] == ADDR_CHV_HI && paddr[3:2] == 2'(i);
            if (i % 2 == 1 && linked[i]) begin
                wrSc[i] = 1'b0; // [RULE_03]
            end
            // buffer bit beats unbuffered select
            if (i % 2 == 0) begin
                oc[i] = (chc_r[i].elsHi || chc_r[i].elsLo) && (chc_r[i].bufSel || chc_r[i].unbufSel); // [RULE_05] [RULE_20]
            end else begin
                oc[i] = !linked[i] && (chc_r[i].elsHi || chc_r[i].elsLo) && chc_r[i].unbufSel; // [RULE_20]
            end
            cap[i] = !(i % 2 == 1 && linked[i]) && !ctl_r.halt && !chc_r[i].unbufSel && !chc_r[i].bufSel &&
                     ((chc_r[i].elsLo && channelPinIn[i] && !pinPrev_r[i]) ||
                      (chc_r[i].elsHi && !channelPinIn[i] && pinPrev_r[i])); // [RULE_20]
            // active member of a linked pair
            cmpVal = (i % 2 == 0 && linked[i] && sel_r[i / 2]) ? cmp_r[i | 1] : cmp_r[i]; // [RULE_02]
            cmpHit[i] = tick && oc[i] && (cnt_r == cmpVal); // [RULE_24]
            chEvt[i] = cmpHit[i] || cap[i]; // [RULE_14]
            channelPinOe[i] = oc[i]; // [RULE_03] [RULE_04]
        end

        // channel registers, flags and outputs
        for (int i = 0; i < 4; i++) begin
            if (wrSc[i]) begin
                chc_nxt[i] = tbp_chc_s'(pwdata[CH_CTL_W-1:0]);
                if (i % 2 == 1) begin
                    chc_nxt[i].bufSel = 1'b0;
                end
            end
            fa = flag_step(chFlag_r[i], chArm_r[i], chEvt[i],
                           setupRd && paddr[7:4] == ADDR_CHSC_HI && paddr[3:2] == 2'(i),
                           wrSc[i] && !pwdata[CH_FLAG_BIT]); // [RULE_15]
            chFlag_nxt[i] = fa[1]; // [RULE_14]
            chArm_nxt[i] = fa[0];
            if (wrV[i]) begin
                cmp_nxt[i] = pwdata[15:0];
            end
            if (cap[i]) begin
                cmp_nxt[i] = cnt_r;
            end
            if (!chc_r[i].elsHi && !chc_r[i].elsLo) begin
                out_nxt[i] = !chc_r[i].unbufSel;
            end else if (oc[i]) begin
                if (chc_r[i].maxDuty && chc_r[i].tov) begin
                    out_nxt[i] = !chc_r[i].elsLo; // [RULE_12]
                end else if (ovfEvt && chc_r[i].tov) begin
                    out_nxt[i] = !out_r[i]; // [RULE_11] [RULE_24]
                end else if (cmpHit[i]) begin
                    if (chc_r[i].elsHi) begin
                        out_nxt[i] = chc_r[i].elsLo;
                    end else begin
                        out_nxt[i] = !out_r[i];
                    end
                end
            end
        end

        // pair bookkeeping: even member first, last write governs
        for (int p = 0; p < 2; p++) begin
            if (!chc_r[2 * p].bufSel) begin
                lastWr_nxt[p] = 1'b0; // [RULE_01] [RULE_04]
                sel_nxt[p] = 1'b0;
            end else begin
                if (wrV[2 * p + 1]) begin
                    lastWr_nxt[p] = 1'b1; // [RULE_02]
                end else if (wrV[2 * p]) begin
                    lastWr_nxt[p] = 1'b0; // [RULE_02]
                end
                if (ovfEvt) begin
                    sel_nxt[p] = lastWr_r[p]; // [RULE_02]
                end
            end
        end

        // read data captured in the setup phase
        if (setupRd) begin
            rdata_nxt = 32'h0000_0000;
            if (paddr == ADDR_SC) begin
                rdata_nxt[SC_OVF_BIT] = ovf_r;
                rdata_nxt[SC_OVIE_BIT] = ctl_r.ovIe;
                rdata_nxt[SC_HALT_BIT] = ctl_r.halt;
                rdata_nxt[SC_PS_LSB +: 3] = ctl_r.ps; // reset bit reads zero [RULE_22]
            end else if (paddr == ADDR_CNT) begin
                rdata_nxt[15:0] = cnt_r;
            end else if (paddr == ADDR_MOD) begin
                rdata_nxt[15:0] = mod_r;
            end else if (paddr[7:4] == ADDR_CHSC_HI && paddr[1:0] == 2'b00) begin
                if (!(paddr[2] && linked[paddr[3:2]])) begin
                    rdata_nxt[CH_FLAG_BIT] = chFlag_r[paddr[3:2]];
                    rdata_nxt[CH_CTL_W-1:0] = chc_r[paddr[3:2]]; // [RULE_03]
                end
            end else if (paddr[7:4] == ADDR_CHV_HI && paddr[1:0] == 2'b00) begin
                rdata_nxt[15:0] = cmp_r[paddr[3:2]];
            end
        end
    end

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= CTL_RST; // [RULE_16] [RULE_21]
            for (int i = 0; i < 4; i++) begin
                chc_r[i] <= CHC_RST;
                cmp_r[i] <= CNT_RST;
            end
            chFlag_r <= 4'h0;
            chArm_r <= 4'h0;
            out_r <= 4'h0;
            pinPrev_r <= 4'h0;
            sel_r <= 2'h0;
            lastWr_r <= 2'h0;
            ovf_r <= 1'b0; // [RULE_16]
            ovArm_r <= 1'b0;
            cnt_r <= CNT_RST;
            mod_r <= MOD_RST;
            presc_r <= 6'd0;
            ext_r <= 3'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctl_r <= ctl_nxt;
            chc_r <= chc_nxt;
            cmp_r <= cmp_nxt;
            chFlag_r <= chFlag_nxt;
            chArm_r <= chArm_nxt;
            out_r <= out_nxt;
            pinPrev_r <= pinPrev_nxt;
            sel_r <= sel_nxt;
            lastWr_r <= lastWr_nxt;
            ovf_r <= ovf_nxt;
            ovArm_r <= ovArm_nxt;
            cnt_r <= cnt_nxt;
            mod_r <= mod_nxt;
            presc_r <= presc_nxt;
            ext_r <= ext_nxt;
            rdata_r <= rdata_nxt;
        end
    end

endmodule

// ===== testbench/tbp_timer_pwm_properties.sv
// concurrent checks on the timer pwm top ports
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/1ps

module tbp_timer_pwm_props
    import tbp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic waitMode,
    input wire logic extCountClock,
    input wire logic extClkInputForce,
    input wire logic [3:0] channelPinIn,
    input wire logic [3:0] channelPinOut,
    input wire logic [3:0] channelPinOe,
    input wire logic irq
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_wr(a);
        s_acc ##0 (pwrite && !waitMode && paddr == a);
    endsequence
    sequence s_rd(a);
        s_acc ##0 (!pwrite && !waitMode && paddr == a);
    endsequence

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    a_bus_ready: assert property (s_acc |-> pready)
        else $error("access without ready");
    a_wait_refused: assert property (s_acc ##0 waitMode |-> pslverr)
        else $error("access in wait not refused");
    a_unmapped_error: assert property (s_acc ##0 (paddr == 8'hFC) |-> pslverr)
        else $error("unmapped access not refused");
    a_reset_bit_zero: assert property (s_rd(ADDR_SC) |-> !prdata[SC_RST_BIT])
        else $error("counter reset bit reads one");
    a_ext_pin_input: assert property (s_wr(ADDR_SC) ##0 (pwdata[2:0] == PS_EXT) |=> extClkInputForce)
        else $error("external clock pin not forced to input");
    a_ext_pin_free: assert property (s_wr(ADDR_SC) ##0 (pwdata[2:0] != PS_EXT) |=> !extClkInputForce)
        else $error("external clock pin forced without code");
    a_pair01_frees: assert property (s_wr(8'h10) ##0 pwdata[5] |=> !channelPinOe[1])
        else $error("pin 1 still driven while linked");
    a_pair23_frees: assert property (s_wr(8'h18) ##0 pwdata[5] |=> !channelPinOe[3])
        else $error("pin 3 still driven while linked");
    a_ovf_irq_on: assert property (s_rd(ADDR_SC) ##0 (prdata[7] && prdata[6]) |-> irq)
        else $error("enabled overflow gives no request");
    a_full_duty: assert property (s_wr(8'h10) ##0 (pwdata[5:0] == 6'h1B) |-> ##2 channelPinOut[0])
        else $error("full duty not forced high");
    a_compare_drives: assert property (s_wr(8'h10) ##0 (pwdata[5:2] == 4'h6) |=> channelPinOe[0])
        else $error("compare channel does not drive pin");
endmodule

bind tbp_timer_pwm tbp_timer_pwm_props u_props (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .waitMode(waitMode), .extCountClock(extCountClock), .extClkInputForce(extClkInputForce),
    .channelPinIn(channelPinIn), .channelPinOut(channelPinOut), .channelPinOe(channelPinOe),
    .irq(irq)
);

// ===== testbench/tbp_load_model.sv
// load on the four channel pins, resolving each pin level
// assumes the design drives a pin only while its enable is high
`timescale 1ns/1ps

module tbp_load_model (
    input wire logic clock,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    output logic [3:0] pinLevel
);
    logic [3:0] level_r = 4'h0;

    // remember each level so a released pin can flip
    always_ff @(posedge clock) begin
        level_r <= pinLevel;
    end
    // no pull on the pins: a released pin never keeps its last value
    assign pinLevel = (pinOe & pinOut) | (~pinOe & ~level_r);
endmodule

// ===== testbench/tbp_timer_pwm_tb_top.sv
// self-checking bench for the timer pwm block over apb
// assumes the load model on the pins and the bound checker
`timescale 1ns/1ps

module tbp_timer_pwm_tb_top
    import tbp_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic waitMode = 1'b0;
    logic extCountClock = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic extClkInputForce;
    logic irq;
    logic lastErr;
    logic [31:0] lastRdata;
    logic [3:0] pinLevel;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    int compares = 0;
    int miscompares = 0;

    // 125 mhz clock
    always #4 clock = ~clock;

    tbp_timer_pwm dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .waitMode(waitMode), .extCountClock(extCountClock), .extClkInputForce(extClkInputForce),
        .channelPinIn(pinLevel), .channelPinOut(pinOut), .channelPinOe(pinOe), .irq(irq));
    tbp_load_model load (.clock(clock), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        chk(32'(seen), 32'(exp));
    endtask
    // one apb transfer; answer taken at its completing edge, then one idle edge
    // so a following call never reassigns psel in the same time step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            test_done();
        end
        lastErr = pslverr;
        lastRdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000);
        chk(lastRdata, {16'h0000, e});
    endtask
    function automatic logic [7:0] chAddr(input logic [7:0] base, input int ch);
        return base + 8'(4 * ch);
    endfunction
    // count high cycles of a pin over four periods of ten ticks
    task automatic measure(input int ch, input int exp);
        int h;
        h = 0;
        repeat (20) @(posedge clock);
        repeat (40) begin
            @(negedge clock);
            if (pinLevel[ch] === 1'b1) begin
                h++;
            end
        end
        @(posedge clock);
        chk(32'(h), 32'(exp));
    endtask
    task automatic initPwm(input int ch, input logic [15:0] ctl, input logic [15:0] wid);
        wr(ADDR_SC, 16'h0030);
        wr(ADDR_MOD, 16'h0009);
        wr(chAddr(8'h20, ch), wid);
        wr(chAddr(8'h10, ch), ctl);
        wr(ADDR_SC, 16'h0000);
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(ADDR_SC, 16'h0020);
        rd(ADDR_MOD, 16'hFFFF);
        repeat (8) @(posedge clock);
        rd(ADDR_CNT, 16'h0000);
        rd(8'hFC, 16'h0000);
        chk1(lastErr, 1'b1);
        $display("test reset done");
        initPwm(0, 16'h001A, 16'h0004);
        measure(0, 20);
        rd(8'h10, 16'h009A);
        chk1(irq, 1'b0);
        wr(8'h10, 16'h001B);
        measure(0, 40);
        wr(8'h10, 16'h0018);
        measure(0, 0);
        $display("test duty done");
        wr(ADDR_SC, 16'h0020);
        rd(ADDR_SC, 16'h00A0);
        wr(ADDR_SC, 16'h0060);
        rd(ADDR_SC, 16'h0060);
        wr(ADDR_SC, 16'h00E0);
        rd(ADDR_SC, 16'h0060);
        wr(ADDR_SC, 16'h0040);
        repeat (12) @(posedge clock);
        chk1(irq, 1'b1);
        rd(ADDR_SC, 16'h00C0);
        repeat (12) @(posedge clock);
        // overflow after the arming read voids the clear; halt so none can set it again
        wr(ADDR_SC, 16'h0060);
        rd(ADDR_SC, 16'h00E0);
        wr(ADDR_SC, 16'h00C0);
        $display("test flag done");
        wr(8'h10, 16'h001A);
        waitMode <= 1'b1;
        wr(ADDR_SC, 16'h0020);
        chk1(lastErr, 1'b1);
        measure(0, 20);
        chk1(irq, 1'b1);
        waitMode <= 1'b0;
        rd(ADDR_SC, 16'h00C0);
        // timer stopped before wait: counter stays at zero, no request
        wr(ADDR_SC, 16'h0030);
        waitMode <= 1'b1;
        repeat (20) @(posedge clock);
        chk1(irq, 1'b0);
        waitMode <= 1'b0;
        rd(ADDR_CNT, 16'h0000);
        $display("test wait done");
        for (int p = 0; p < 4; p += 2) begin
            initPwm(p, 16'h003A, 16'h0002);
            chk1(pinOe[p + 1], 1'b0);
            measure(p, 12);
            rd(chAddr(8'h10, p + 1), 16'h0000);
            wr(chAddr(8'h20, p + 1), 16'h0006);
            measure(p, 28);
            wr(chAddr(8'h20, p), 16'h0004);
            measure(p, 20);
        end
        $display("test pairs done");
        wr(ADDR_SC, 16'h0037);
        wr(ADDR_SC, 16'h0007);
        chk1(extClkInputForce, 1'b1);
        repeat (5) begin
            extCountClock <= 1'b1;
            repeat (3) @(posedge clock);
            extCountClock <= 1'b0;
            repeat (3) @(posedge clock);
        end
        repeat (4) @(posedge clock);
        rd(ADDR_CNT, 16'h0005);
        wr(ADDR_SC, 16'h0020);
        chk1(extClkInputForce, 1'b0);
        $display("test external clock done");
        test_done();
    end
endmodule
